// ### hdl/hrp_consts.svh
`ifndef HRP_CONSTS_SVH
`define HRP_CONSTS_SVH

// System clock period in ns.
`define HRP_CLK_NS 10
// Serial frame length in bits and the bit of the control byte that marks a read.
`define HRP_SER_BITS 16
`define HRP_CTRL_RD_BIT 7
// Host-made serial clock: system cycles per half period.
`define HRP_SCLK_HALF 8
// Host parallel timing in system cycles.
`define HRP_PAR_SETUP 2
`define HRP_PAR_STROBE 10
// Least wait after reset before the first access, in ns, and its cycle count.
`define HRP_RST_WAIT_NS 2000000
`define HRP_RST_WAIT_CYC (`HRP_RST_WAIT_NS / `HRP_CLK_NS)
// Least width of a hardware reset pulse, in ns.
`define HRP_RST_PULSE_NS 100
// Reset value of the device test mode flag.
`define HRP_TEST_MODE_RST 1'b1

`endif

// ### hdl/hrp_pkg.sv
package hrp_pkg;

  // One register byte.
  typedef logic [7:0] hrp_byte_t;

  // Host sequencer states.
  typedef enum logic [2:0] {
    HS_BOOT,
    HS_IDLE,
    HS_SETUP,
    HS_STROBE,
    HS_SHIFT,
    HS_RELEASE,
    HS_GAP
  } hrp_hstate_e;

endpackage

// ### hdl/hrp_if.sv
`timescale 1ns/1ps

// Pins between the host and the device; the shared wires are resolved here.
interface hrp_if;
  logic cs_n;            // Port select, active low.
  logic [7:0] addr;      // Parallel address.
  logic rw_sdi;          // Direction, write strobe or serial input.
  logic ds_sclk;         // Data strobe, load strobe or serial clock.
  logic bus_style_sel;   // Low: strobe plus direction; high: separate strobes.
  logic serial_port_select; // Low: parallel; high: serial.
  logic [7:0] host_d_o;  // Host data drive value.
  logic [7:0] host_d_oe; // Host data drive enable.
  logic [7:0] dev_d_o;   // Device data drive value.
  logic [7:0] dev_d_oe;  // Device data drive enable.
  logic int_o;           // Device interrupt drive value (always low).
  logic int_oe;          // Device interrupt pull-down enable.
  logic [7:0] d;         // Resolved data wires.
  logic int_n;           // Resolved interrupt wire with pull-up.

  // Each data wire carries whichever end drives it; undriven wires rest low.
  for (genvar i = 0; i < 8; i++) begin : g_d
    assign d[i] = dev_d_oe[i] ? dev_d_o[i] : (host_d_oe[i] ? host_d_o[i] : 1'b0);
  end

  // Open drain: pulled high unless the device pulls it down.
  assign int_n = int_oe ? int_o : 1'b1;

  modport dev (
    input cs_n, addr, rw_sdi, ds_sclk, bus_style_sel, serial_port_select, d,
    output dev_d_o, dev_d_oe, int_o, int_oe
  );
  modport host (
    input d, int_n,
    output cs_n, addr, rw_sdi, ds_sclk, bus_style_sel, serial_port_select,
    output host_d_o, host_d_oe
  );
endinterface

// ### hdl/hrp_host.sv
`timescale 1ns/1ps
`include "hrp_consts.svh"

// Host end: turns one request into a parallel or serial access on the pins.
module hrp_host #(
  parameter int RST_WAIT_CYC = `HRP_RST_WAIT_CYC,
  parameter int SCLK_HALF = `HRP_SCLK_HALF
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  hrp_if.host bus,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire hrp_pkg::hrp_byte_t req_addr_i,
  input wire hrp_pkg::hrp_byte_t req_wdata_i,
  input wire logic serial_i,
  input wire logic style_i,
  output logic ready_o,
  output logic done_o,
  output hrp_pkg::hrp_byte_t rdata_o,
  output logic irq_o
);
  import hrp_pkg::*;

  hrp_hstate_e state_r;  // Sequencer state.
  logic [31:0] cnt_r;    // Cycle counter of the current step.
  logic [4:0] bits_r;    // Serial bits sent.
  logic wr_r;            // Current access is a write.
  logic ser_r;           // Current mode is serial.
  logic sty_r;           // Current parallel style.
  logic sclk_r;          // Serial clock level.
  logic [15:0] tx_r;     // Serial transmit shifter.
  logic [8:0] meta_r;    // First synchroniser stage for data and interrupt.
  logic [8:0] sync_r;    // Second synchroniser stage.

  // Device outputs come from another domain and pass two flip-flops.
  always_ff @(posedge clk_sys_i) begin
    meta_r <= {bus.int_n, bus.d};
    sync_r <= meta_r;
  end

  // The interrupt line is active low; the user sees it active high.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= ~sync_r[8];
    end
  end

  // Main sequencer: owns every pin that the host drives.
  always_ff @(posedge clk_sys_i) begin
    done_o <= 1'b0;
    if (srst_i) begin
      state_r <= HS_BOOT;
      cnt_r <= 32'h0;
      bits_r <= 5'h0;
      wr_r <= 1'b0;
      ser_r <= 1'b0;
      sty_r <= 1'b0;
      sclk_r <= 1'b0;
      tx_r <= 16'h0;
      ready_o <= 1'b0;
      rdata_o <= 8'h00;
      bus.cs_n <= 1'b1; // Port select high at least once after power-up.
      bus.addr <= 8'h00;
      bus.rw_sdi <= 1'b1;
      bus.ds_sclk <= 1'b1;
      bus.bus_style_sel <= 1'b0;
      bus.serial_port_select <= 1'b0;
      bus.host_d_o <= 8'h00;
      bus.host_d_oe <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 32'h1;
      unique case (state_r)
        HS_BOOT: begin
          // No access until the reset wait has passed.
          if (cnt_r >= 32'(RST_WAIT_CYC)) begin
            state_r <= HS_IDLE;
            ready_o <= 1'b1;
          end
        end
        HS_IDLE: begin
          if (req_i) begin
            ready_o <= 1'b0;
            wr_r <= req_write_i;
            ser_r <= serial_i;
            sty_r <= style_i;
            // Mode pins: serial low/high and style low/high.
            bus.serial_port_select <= serial_i;
            bus.bus_style_sel <= style_i;
            bus.cs_n <= 1'b0; // A fresh falling edge for each access.
            cnt_r <= 32'h0;
            if (serial_i) begin
              // Control byte with read flag and address, then data.
              tx_r <= {~req_write_i, req_addr_i[6:0], req_wdata_i};
              bus.rw_sdi <= ~req_write_i;
              bus.ds_sclk <= 1'b0;
              bus.addr <= 8'h00;
              sclk_r <= 1'b0;
              bits_r <= 5'h0;
              state_r <= HS_SHIFT;
            end else begin
              bus.addr <= req_addr_i; // Address picks the register.
              bus.host_d_o <= req_wdata_i; // Host drives data on writes.
              bus.host_d_oe <= {8{req_write_i}};
              bus.rw_sdi <= style_i ? 1'b1 : ~req_write_i; // High reads.
              bus.ds_sclk <= 1'b1;
              state_r <= HS_SETUP;
            end
          end
        end
        HS_SETUP: begin
          if (cnt_r == 32'(`HRP_PAR_SETUP - 1)) begin
            cnt_r <= 32'h0;
            state_r <= HS_STROBE;
            if (sty_r) begin
              bus.rw_sdi <= ~wr_r; // Store strobe low writes.
              bus.ds_sclk <= wr_r; // Load strobe low reads.
            end else begin
              bus.ds_sclk <= 1'b0; // Data strobe low qualifies.
            end
          end
        end
        HS_STROBE: begin
          if (cnt_r == 32'(`HRP_PAR_STROBE - 1)) begin
            cnt_r <= 32'h0;
            if (!wr_r) begin
              rdata_o <= sync_r[7:0];
            end
            bus.ds_sclk <= 1'b1;
            if (sty_r) begin
              bus.rw_sdi <= 1'b1;
            end
            state_r <= HS_RELEASE;
          end
        end
        HS_SHIFT: begin
          if (cnt_r == 32'(SCLK_HALF - 1)) begin
            cnt_r <= 32'h0;
            sclk_r <= ~sclk_r;
            bus.ds_sclk <= ~sclk_r;
            if (sclk_r) begin
              // At the falling edge: take the device bit, present the next.
              rdata_o <= {rdata_o[6:0], sync_r[0]};
              tx_r <= {tx_r[14:0], 1'b0};
              bus.rw_sdi <= tx_r[14];
              bits_r <= bits_r + 5'h1;
              if (bits_r == 5'(`HRP_SER_BITS - 1)) begin
                state_r <= HS_RELEASE;
              end
            end
          end
        end
        HS_RELEASE: begin
          // Port select stays low until the access is over.
          if (cnt_r == 32'(`HRP_PAR_SETUP - 1)) begin
            cnt_r <= 32'h0;
            bus.cs_n <= 1'b1;
            bus.host_d_oe <= 8'h00;
            bus.rw_sdi <= 1'b1;
            bus.ds_sclk <= ~ser_r;
            state_r <= HS_GAP;
          end
        end
        HS_GAP: begin
          if (cnt_r == 32'(`HRP_PAR_SETUP - 1)) begin
            done_o <= 1'b1;
            ready_o <= 1'b1;
            state_r <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// ### hdl/hrp_dev.sv
`timescale 1ns/1ps
`include "hrp_consts.svh"

module hrp_dev (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  hrp_if.dev bus,
  output hrp_pkg::hrp_byte_t reg_addr_o,
  output hrp_pkg::hrp_byte_t reg_wdata_o,
  output logic reg_we_o,
  output logic reg_re_o,
  input wire hrp_pkg::hrp_byte_t reg_rdata_i,
  input wire logic irq_pending_i,
  output logic test_mode_o,
  output logic serial_mode_o
);
  import hrp_pkg::*;

  // Decodes the two strobe pins into {access active, access is a read}.
  function automatic logic [1:0] acc_decode(input logic style, input logic rw,
                                            input logic ds);
    logic [1:0] res;
    res = 2'b00;
    if (style) begin
      // Separate strobes: store low writes, load low reads.
      res[1] = ~rw | ~ds;
      res[0] = ~ds;
    end else begin
      // Data strobe low qualifies; direction high reads.
      res[1] = ~ds;
      res[0] = rw;
    end
    return res;
  endfunction

  logic [20:0] meta_r;    // First synchroniser stage of all pins.
  logic [20:0] sync_r;    // Second stage; the only one the logic reads.
  logic cs_low;           // Port selected.
  logic ser_mode;         // Serial mode selected.
  logic sdi_s;            // Synced serial input.
  logic sclk_s;           // Synced serial clock.
  logic [7:0] addr_s;     // Synced address.
  logic [7:0] d_s;        // Synced data wires.
  logic [1:0] acc;        // Decoded parallel access.
  logic sclk_prev_r;      // Serial clock one cycle ago.
  logic sclk_rise;        // Serial clock rising edge seen.
  logic sclk_fall;        // Serial clock falling edge seen.
  logic [4:0] bits_r;     // Serial bits received in this frame.
  logic [6:0] shift_r;    // Serial input shifter.
  logic ser_rd_r;         // Serial frame is a read.
  logic [7:0] ser_addr_r; // Serial frame address.
  logic ser_ctrl_ev;      // Control byte completes this cycle.
  logic ser_data_ev;      // Data byte completes this cycle.
  logic par_done_r;       // Access already taken in this select frame.
  logic par_rd_r;         // Parallel read in progress.
  logic wr_arm_r;         // Parallel write waiting for strobe release.
  logic par_start;        // Parallel access begins this cycle.
  logic rd_pend_r;        // Read data from the user arrives this cycle.
  logic [7:0] rdata_r;    // Captured read data.

  // Pins come from the host's domain and pass two flip-flops.
  always_ff @(posedge clk_sys_i) begin
    meta_r <= {bus.cs_n, bus.rw_sdi, bus.ds_sclk, bus.bus_style_sel,
               bus.serial_port_select, bus.addr, bus.d};
    sync_r <= meta_r;
  end

  // Named views of the synced pins.
  assign cs_low = ~sync_r[20];
  assign sdi_s = sync_r[19];
  assign sclk_s = sync_r[18];
  assign ser_mode = sync_r[16]; // High selects serial, low parallel.
  assign addr_s = sync_r[15:8];
  assign d_s = sync_r[7:0];
  // Style select is read only by the parallel decode.
  assign acc = acc_decode(sync_r[17], sdi_s, sclk_s);

  // Serial clock edges found by comparing with the previous sample.
  // Reset to the high level that the strobe pin rests at, so no false edge follows reset.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sclk_prev_r <= 1'b1;
    end else begin
      sclk_prev_r <= sclk_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_prev_r;
  assign sclk_fall = ~sclk_s & sclk_prev_r;

  // Frame milestones on the rising edge that brings in the 8th and 16th bit.
  assign ser_ctrl_ev = ser_mode & cs_low & sclk_rise &
                       (bits_r == 5'(`HRP_SER_BITS / 2 - 1));
  assign ser_data_ev = ser_mode & cs_low & sclk_rise &
                       (bits_r == 5'(`HRP_SER_BITS - 1));

  // Serial receiver: samples the input on rising serial clock edges.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      bits_r <= 5'h0;
      shift_r <= 7'h0;
      ser_rd_r <= 1'b0;
      ser_addr_r <= 8'h00;
    end else if (!cs_low || !ser_mode) begin
      // Deselect ends the frame and forgets any partial bits.
      bits_r <= 5'h0;
      ser_rd_r <= 1'b0;
    end else if (sclk_rise && bits_r < 5'(`HRP_SER_BITS)) begin
      shift_r <= {shift_r[5:0], sdi_s}; // MSB first.
      bits_r <= bits_r + 5'h1;
      if (ser_ctrl_ev) begin
        // Top bit of the control byte marks a read; the rest is the address.
        ser_rd_r <= shift_r[`HRP_CTRL_RD_BIT - 1];
        ser_addr_r <= {1'b0, shift_r[5:0], sdi_s};
      end
    end
  end

  // Parallel access begins once per select frame on the first active strobe.
  assign par_start = ~ser_mode & cs_low & acc[1] & ~par_done_r;

  // Parallel tracker: one access per falling edge of select.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      par_done_r <= 1'b0;
      par_rd_r <= 1'b0;
      wr_arm_r <= 1'b0;
    end else if (!cs_low || ser_mode) begin
      // Select high re-arms the port and stops any read drive.
      par_done_r <= 1'b0;
      par_rd_r <= 1'b0;
      wr_arm_r <= 1'b0;
    end else if (par_start) begin
      par_done_r <= 1'b1;
      par_rd_r <= acc[0];
      wr_arm_r <= ~acc[0];
    end else if (wr_arm_r && !acc[1]) begin
      wr_arm_r <= 1'b0;
    end
  end

  // User-side register strobes, address and write data.
  always_ff @(posedge clk_sys_i) begin
    reg_we_o <= 1'b0;
    reg_re_o <= 1'b0;
    if (srst_i) begin
      reg_addr_o <= 8'h00;
      reg_wdata_o <= 8'h00;
    end else if (ser_ctrl_ev && shift_r[`HRP_CTRL_RD_BIT - 1]) begin
      // Serial read is fetched as soon as the control byte is in.
      reg_re_o <= 1'b1;
      reg_addr_o <= {1'b0, shift_r[5:0], sdi_s};
    end else if (ser_data_ev && !ser_rd_r) begin
      // Serial write completes with the last data bit.
      reg_we_o <= 1'b1;
      reg_addr_o <= ser_addr_r;
      reg_wdata_o <= {shift_r[6:0], sdi_s};
    end else if (par_start && acc[0]) begin
      reg_re_o <= 1'b1;
      reg_addr_o <= addr_s;
    end else if (wr_arm_r && (!acc[1] || !cs_low)) begin
      // Parallel write is taken at strobe release, when the data has settled.
      reg_we_o <= 1'b1;
      reg_addr_o <= addr_s;
      reg_wdata_o <= d_s;
    end
  end

  // Read data from the user side is taken one cycle after the read strobe.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rd_pend_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      rd_pend_r <= reg_re_o;
      if (rd_pend_r) begin
        rdata_r <= reg_rdata_i;
      end
    end
  end

  // Data pin drivers for parallel reads and serial output.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      bus.dev_d_o <= 8'h00;
      bus.dev_d_oe <= 8'h00;
    end else if (ser_mode) begin
      // Serial output lives on data bit zero; other bits stay released.
      bus.dev_d_oe <= {7'h0, cs_low & ser_rd_r};
      if (!cs_low) begin
        bus.dev_d_o <= 8'h00;
      end else if (sclk_fall && ser_rd_r && bits_r >= 5'(`HRP_SER_BITS / 2)) begin
        // Next bit changes on the falling serial clock, MSB first.
        bus.dev_d_o <= {7'h0, rdata_r[~bits_r[2:0]]};
      end
    end else begin
      // Drive the read value while the read strobe stays active.
      bus.dev_d_oe <= {8{par_rd_r & cs_low & acc[1] & acc[0]}};
      bus.dev_d_o <= rdata_r;
    end
  end

  // Interrupt pulls the open-drain line low while anything is pending.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      bus.int_o <= 1'b0;
      bus.int_oe <= 1'b0;
    end else begin
      bus.int_o <= 1'b0;
      bus.int_oe <= irq_pending_i;
    end
  end

  // Test modes are left once select has been seen high.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      test_mode_o <= `HRP_TEST_MODE_RST;
      serial_mode_o <= 1'b0;
    end else begin
      serial_mode_o <= ser_mode;
      if (!cs_low) begin
        test_mode_o <= 1'b0;
      end
    end
  end
endmodule

// ### test/hrp_monitor.sv
`timescale 1ns/1ps

// Watches the pins between the host and device ends of the register port.
module hrp_monitor (
  input logic clk_sys_i,
  input logic srst_i,
  input logic cs_n,
  input logic [7:0] addr,
  input logic rw_sdi,
  input logic ds_sclk,
  input logic bus_style_sel,
  input logic serial_port_select,
  input logic [7:0] host_d_o,
  input logic [7:0] host_d_oe,
  input logic [7:0] dev_d_o,
  input logic [7:0] dev_d_oe,
  input logic int_o,
  input logic int_oe,
  input logic [7:0] d,
  input logic int_n
);
  // Every check runs on the system clock and rests while reset is high.
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  // The device lets go of the data wires once the port has been deselected a while.
  drive_release_a: assert property (cs_n [*4] |-> dev_d_oe == 8'h00)
    else $error("device drives data while deselected");
  // The two ends never drive the same data wire together.
  no_contention_a: assert property ((dev_d_oe & host_d_oe) == 8'h00)
    else $error("both ends drive the data wires");
  // In serial mode only data bit zero may carry the device's output.
  serial_pin_a: assert property (serial_port_select && $past(serial_port_select, 4)
    |-> dev_d_oe[7:1] == 7'h00)
    else $error("device drives upper data wires in serial mode");
  // The serial output moves only while the serial clock is low.
  sdo_on_fall_a: assert property ($changed(dev_d_o[0]) && dev_d_oe[0] && $past(dev_d_oe[0])
    |-> !ds_sclk)
    else $error("serial output changed while serial clock high");
  // The host moves the serial input only while the serial clock is low.
  sdi_setup_a: assert property (serial_port_select && !cs_n && !$past(cs_n)
    && $changed(rw_sdi) |-> !ds_sclk)
    else $error("serial input changed while serial clock high");
  // A data or load strobe begins only inside a select frame.
  strobe_in_frame_a: assert property (!serial_port_select && $fell(ds_sclk) |-> !cs_n)
    else $error("strobe asserted with port deselected");
  // Strobe and direction style: the direction decides who drives the data.
  dir_drive_a: assert property (!serial_port_select && !bus_style_sel && !cs_n && !ds_sclk
    |-> host_d_oe == (rw_sdi ? 8'h00 : 8'hff))
    else $error("host data drive disagrees with direction");
  // Separate strobe style: the store strobe means the host writes and the device is quiet.
  store_drive_a: assert property (!serial_port_select && bus_style_sel && !cs_n && !rw_sdi
    |-> host_d_oe == 8'hff && dev_d_oe == 8'h00)
    else $error("store strobe without host data drive");
  // A read through the data strobe is answered while the strobe still stands.
  strobe_read_a: assert property (!serial_port_select && !bus_style_sel && !cs_n && rw_sdi
    && $fell(ds_sclk) |-> ##[1:9] dev_d_oe == 8'hff)
    else $error("strobe read not answered");
  // A read through the load strobe is answered while the strobe still stands.
  load_read_a: assert property (!serial_port_select && bus_style_sel && !cs_n
    && $fell(ds_sclk) |-> ##[1:9] dev_d_oe == 8'hff)
    else $error("load strobe read not answered");
  // The interrupt pin is only ever pulled down, never driven high.
  open_drain_a: assert property (int_oe |-> int_o == 1'b0)
    else $error("interrupt pin driven high");

  // The main kinds of traffic that the run should reach.
  cover property (!serial_port_select && !bus_style_sel && dev_d_oe == 8'hff);
  cover property (!serial_port_select && bus_style_sel && !rw_sdi && !cs_n);
  cover property (serial_port_select && dev_d_oe[0]);
  cover property (!int_n);
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps

// Joins the host and device ends, drives both user sides and checks the results.
module tb_top;
  import hrp_pkg::*;
  localparam int RST_WAIT = 10; // Short post-reset wait for simulation.
  localparam int SCLK_HALF = 8;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic req_i = 1'b0, req_write_i = 1'b0, serial_i = 1'b0, style_i = 1'b0;
  hrp_byte_t req_addr_i = 8'h00, req_wdata_i = 8'h00, rdata_o, reg_addr_o, reg_wdata_o;
  hrp_byte_t reg_rdata_i = 8'h00, b_addr, b_wdata, ra, rd;
  logic ready_o, done_o, irq_o, reg_we_o, reg_re_o, test_mode_o, serial_mode_o, b_we, b_test;
  logic irq_pending_i = 1'b0;
  logic sty;
  int miscompares = 0, check_count = 0, cycles = 0, b_we_cnt = 0, md;
  integer seed = 32'h06e9;
  logic [16:0] exp_dev[$]; // Expected device access: read flag, address, write data.
  logic [8:0] exp_host[$]; // Expected host result: read flag, read data.
  logic [16:0] de;
  logic [8:0] he;

  hrp_if bus_a();
  hrp_if bus_b(); // Second link, driven by the bench in the host's place.

  hrp_host #(.RST_WAIT_CYC(RST_WAIT), .SCLK_HALF(SCLK_HALF)) u_hrp_host (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .bus(bus_a), .req_i(req_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .serial_i(serial_i), .style_i(style_i), .ready_o(ready_o), .done_o(done_o),
    .rdata_o(rdata_o), .irq_o(irq_o));
  hrp_dev u_hrp_dev (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .bus(bus_a), .reg_addr_o(reg_addr_o),
    .reg_wdata_o(reg_wdata_o), .reg_we_o(reg_we_o), .reg_re_o(reg_re_o),
    .reg_rdata_i(reg_rdata_i), .irq_pending_i(irq_pending_i), .test_mode_o(test_mode_o),
    .serial_mode_o(serial_mode_o));
  hrp_dev u_hrp_dev_b (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .bus(bus_b), .reg_addr_o(b_addr),
    .reg_wdata_o(b_wdata), .reg_we_o(b_we), .reg_re_o(), .reg_rdata_i(8'h00),
    .irq_pending_i(1'b0), .test_mode_o(b_test), .serial_mode_o());
  hrp_monitor u_hrp_monitor (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .cs_n(bus_a.cs_n), .addr(bus_a.addr),
    .rw_sdi(bus_a.rw_sdi), .ds_sclk(bus_a.ds_sclk), .bus_style_sel(bus_a.bus_style_sel),
    .serial_port_select(bus_a.serial_port_select), .host_d_o(bus_a.host_d_o),
    .host_d_oe(bus_a.host_d_oe), .dev_d_o(bus_a.dev_d_o), .dev_d_oe(bus_a.dev_d_oe),
    .int_o(bus_a.int_o), .int_oe(bus_a.int_oe), .d(bus_a.d), .int_n(bus_a.int_n));

  // The system clock, 10 ns period.
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Bench-side register contents: a fixed scramble of the address.
  function automatic hrp_byte_t rd_pat(input hrp_byte_t a);
    return {a[3:0], a[7:4]} ^ 8'h3c;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compares one byte result.
  task automatic check_byte(input string what, input hrp_byte_t got, input hrp_byte_t exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Compares one flag result.
  task automatic check_bit(input string what, input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Sets the second link's select and strobe, then lets some cycles pass.
  task automatic pin_b(input logic cs, input logic ds, input int n);
    bus_b.cs_n <= cs;
    bus_b.ds_sclk <= ds;
    repeat (n) @(posedge clk_sys_i);
  endtask

  // One host access; notes the expected device access and host result first.
  task automatic access(input logic ser, input logic st, input logic wr, input hrp_byte_t a,
                        input hrp_byte_t wd);
    hrp_byte_t ea;
    int n;
    ea = ser ? {1'b0, a[6:0]} : a;
    n = 0;
    while (ready_o !== 1'b1 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    exp_dev.push_back({~wr, ea, wr ? wd : 8'h00});
    exp_host.push_back({~wr, rd_pat(ea)});
    req_i <= 1'b1;
    req_write_i <= wr;
    req_addr_i <= a;
    req_wdata_i <= wd;
    serial_i <= ser;
    style_i <= st;
    @(posedge clk_sys_i);
    req_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (done_o !== 1'b1 && n < 400);
    check_bit("access finished", done_o, 1'b1);
    check_bit("mode followed", serial_mode_o, ser);
  endtask

  // Waits a bounded time for the host's interrupt view to reach a level.
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq_o !== v && n < 10) begin
      @(posedge clk_sys_i);
      n++;
    end
    check_bit("interrupt seen", irq_o, v);
  endtask

  // Register file answer, valid the cycle after a read; noise otherwise.
  always @(posedge clk_sys_i) begin
    reg_rdata_i <= (reg_re_o === 1'b1) ? rd_pat(reg_addr_o) : hrp_byte_t'($random(seed));
    if (b_we === 1'b1) begin
      b_we_cnt <= b_we_cnt + 1;
    end
  end

  // Takes the oldest note whenever a result appears and compares.
  always @(posedge clk_sys_i) begin
    if (srst_i === 1'b0 && (reg_we_o === 1'b1 || reg_re_o === 1'b1)) begin
      if (exp_dev.size() == 0) begin
        miscompares++;
        $display("[ERR] %0t unexpected register access", $time);
      end else begin
        de = exp_dev.pop_front();
        check_bit("access kind", reg_re_o, de[16]);
        check_byte("register address", reg_addr_o, de[15:8]);
        if (de[16] === 1'b0) check_byte("write data", reg_wdata_o, de[7:0]);
      end
    end
    if (done_o === 1'b1 && exp_host.size() != 0) begin
      he = exp_host.pop_front();
      if (he[8] === 1'b1) check_byte("read data", rdata_o, he[7:0]);
    end
  end

  // Cuts a hung run short.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("[ERR] %0t run did not finish", $time);
      print_verdict();
    end
  end

  // Main sequence: misuse of the second link, then traffic in every mode, then interrupts.
  initial begin
    bus_b.cs_n = 1'b0;
    bus_b.addr = 8'h11;
    bus_b.rw_sdi = 1'b0;
    bus_b.ds_sclk = 1'b1;
    bus_b.bus_style_sel = 1'b0;
    bus_b.serial_port_select = 1'b0;
    bus_b.host_d_o = 8'haa;
    bus_b.host_d_oe = 8'hff;
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    check_bit("test mode held", b_test, 1'b1);
    pin_b(1'b1, 1'b1, 4);
    check_bit("test mode left", b_test, 1'b0);
    check_bit("port test mode left", test_mode_o, 1'b0);
    pin_b(1'b1, 1'b0, 4);
    pin_b(1'b1, 1'b1, 4);
    check_byte("deselected write", 8'(b_we_cnt), 8'h00);
    pin_b(1'b0, 1'b1, 3);
    pin_b(1'b0, 1'b0, 4);
    pin_b(1'b0, 1'b1, 4);
    pin_b(1'b0, 1'b0, 4);
    pin_b(1'b0, 1'b1, 4);
    pin_b(1'b1, 1'b1, 4);
    check_byte("writes per frame", 8'(b_we_cnt), 8'h01);
    check_byte("frame address", b_addr, 8'h11);
    check_byte("frame data", b_wdata, 8'haa);
    for (int i = 0; i < 24; i++) begin
      md = i % 3;
      ra = (i < 6) ? ((i < 3) ? 8'h00 : 8'hff) : hrp_byte_t'($random(seed));
      rd = hrp_byte_t'($random(seed));
      sty = (md == 2) ? 1'($random(seed)) : logic'(md == 1);
      access(md == 2, sty, ((i / 3) % 2) == 0, ra, rd);
    end
    irq_pending_i <= 1'b1;
    wait_irq(1'b1);
    check_bit("interrupt pin low", bus_a.int_n, 1'b0);
    access(1'b1, 1'b0, 1'b0, 8'h2b, 8'h00);
    check_bit("interrupt still low", bus_a.int_n, 1'b0);
    irq_pending_i <= 1'b0;
    wait_irq(1'b0);
    check_bit("interrupt released", bus_a.int_n, 1'b1);
    repeat (3) @(posedge clk_sys_i);
    check_byte("unanswered notes", 8'(exp_dev.size() + exp_host.size()), 8'h00);
    print_verdict();
  end
endmodule
